/* rtl/digital_input_edge_irq_filter.sv */
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module digital_input_edge_irq_filter
  import di_pkg::*;
#(
  parameter di_pkg::count_t DELAY_0P5_CYC = di_pkg::DELAY_0P5_CYC_DEF,
  parameter di_pkg::count_t DELAY_3_CYC   = di_pkg::DELAY_3_CYC_DEF,
  parameter di_pkg::count_t DELAY_15_CYC  = di_pkg::DELAY_15_CYC_DEF
) (
  // clock and reset
  input  wire logic                      CLOCK_IN,
  input  wire logic                      RESET_IN,
  // apb slave
  input  wire logic                      PSEL_IN,
  input  wire logic                      PENABLE_IN,
  input  wire logic                      PWRITE_IN,
  input  wire logic [di_pkg::ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]               PWDATA_IN,
  input  wire logic [3:0]                PSTRB_IN,
  output logic      [31:0]               PRDATA_OUT,
  output logic                           PREADY_OUT,
  output logic                           PSLVERR_OUT,
  // field inputs
  input  wire logic [di_pkg::NUM_CH-1:0] FIELD_IN,
  // interrupt
  output logic                           IRQ_OUT
);

  import di_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    merge_strb = res;
  endfunction

  // slow inputs cannot use the shortest delay, so they fall back to 0.5 ms
  function automatic count_t delay_limit(input logic [1:0] code,
                                         input logic       fast);
    count_t lim;
    lim = DELAY_0P5_CYC;
    case (code)
      DLY_0P1: lim = fast ? DELAY_0P1_CYC : DELAY_0P5_CYC;
      DLY_0P5: lim = DELAY_0P5_CYC;
      DLY_3:   lim = DELAY_3_CYC;
      DLY_15:  lim = DELAY_15_CYC;
      default: lim = DELAY_0P5_CYC;
    endcase
    delay_limit = lim;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [NUM_CH-1:0] sync1_q;
  logic [NUM_CH-1:0] sync2_q;
  logic [NUM_CH-1:0] sync1_d;
  logic [NUM_CH-1:0] sync2_d;
  logic [NUM_CH-1:0] filt;
  logic [NUM_CH-1:0] prev_q, prev_d;
  logic [NUM_CH-1:0] evt;
  count_t            limit [NUM_CH];

  logic [15:0]       edge_cfg_q, edge_cfg_d;
  logic [7:0]        delay_cfg_q, delay_cfg_d;
  status_t           status_q, status_d;
  status_t           mask_q, mask_d;
  logic              irq_q, irq_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              err_q, err_d;

  logic              setup_ph;
  logic              access_wr;
  logic              hit;
  logic [31:0]       rd_mux;
  logic              sel_edge;
  logic              sel_delay;
  logic              sel_status;
  logic              sel_mask;
  logic [31:0]       edge_wr;
  logic [31:0]       delay_wr;
  logic [31:0]       mask_wr;
  logic [31:0]       clr_wr;
  status_t           set_bits;
  status_t           clr_bits;
  logic              lost;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchroniser: two flops before any logic sees the pins; a first
  // flop caught mid-change gets a whole cycle to settle before the second
  // samples it, and nothing else ever reads the first

  always_comb begin
    sync1_d = FIELD_IN;
    sync2_d = sync1_q;
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel delay filter
  // a new delay setting takes effect at once, even on a count in flight

  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      limit[ch] = delay_limit(delay_cfg_q[2*(ch/DELAY_GROUP) +: 2], FAST_CHANNELS[ch]);
    end
  end

  for (genvar gch = 0; gch < NUM_CH; gch++) begin : g_filter
    input_filter u_filter (
      .CLOCK_IN  (CLOCK_IN),
      .RESET_IN  (RESET_IN),
      .RAW_IN    (sync2_q[gch]),
      .LIMIT_IN  (limit[gch]),
      .LEVEL_OUT (filt[gch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection on the filtered level
  // filter and prev both reset low, the idle level of an open input, so
  // leaving reset never looks like a rising edge

  always_comb begin
    logic [1:0] sel;
    sel    = EDGE_NONE;
    prev_d = filt;
    evt    = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      sel = edge_cfg_q[2*(ch/EDGE_GROUP) +: 2];
      case (sel)
        EDGE_RISE: evt[ch] = filt[ch] & ~prev_q[ch];
        EDGE_FALL: evt[ch] = ~filt[ch] & prev_q[ch];
        EDGE_BOTH: evt[ch] = filt[ch] ^ prev_q[ch];
        default:   evt[ch] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb address decode
  // a misaligned address matches no entry and so answers with an error

  assign setup_ph  = PSEL_IN & ~PENABLE_IN;
  assign access_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;

  always_comb begin
    hit        = 1'b1;
    rd_mux     = 32'h0000_0000;
    sel_edge   = 1'b0;
    sel_delay  = 1'b0;
    sel_status = 1'b0;
    sel_mask   = 1'b0;
    if (PADDR_IN == byte_addr(REG_IDX_IN_LOW)) begin
      rd_mux = {24'h00_0000, filt[7:0]};
    end else if (PADDR_IN == byte_addr(REG_IDX_IN_HIGH)) begin
      rd_mux = {24'h00_0000, filt[15:8]};
    end else if (PADDR_IN == byte_addr(REG_IDX_EDGE_CFG)) begin
      rd_mux   = {16'h0000, edge_cfg_q};
      sel_edge = 1'b1;
    end else if (PADDR_IN == byte_addr(REG_IDX_DELAY_CFG)) begin
      rd_mux    = {24'h00_0000, delay_cfg_q};
      sel_delay = 1'b1;
    end else if (PADDR_IN == byte_addr(REG_IDX_STATUS)) begin
      rd_mux     = {15'h0000, status_q};
      sel_status = 1'b1;
    end else if (PADDR_IN == byte_addr(REG_IDX_MASK)) begin
      rd_mux   = {15'h0000, mask_q};
      sel_mask = 1'b1;
    end else if (PADDR_IN == byte_addr(REG_IDX_FILTERED)) begin
      rd_mux = {16'h0000, filt};
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer: data and error are prepared in the setup cycle, so the
  // access phase always completes at once with flopped outputs

  always_comb begin
    prdata_d = prdata_q;
    err_d    = err_q;
    if (setup_ph) begin
      prdata_d = PWRITE_IN ? 32'h0000_0000 : rd_mux;
      err_d    = ~hit;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = err_q & PSEL_IN & PENABLE_IN;
  assign PRDATA_OUT  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers
  // read-only and unknown addresses select nothing, so writes there vanish

  assign edge_wr  = merge_strb({16'h0000, edge_cfg_q}, PWDATA_IN, PSTRB_IN);
  assign delay_wr = merge_strb({24'h00_0000, delay_cfg_q}, PWDATA_IN, PSTRB_IN);
  assign mask_wr  = merge_strb({15'h0000, mask_q}, PWDATA_IN, PSTRB_IN);
  assign clr_wr   = merge_strb(32'h0000_0000, PWDATA_IN, PSTRB_IN);

  always_comb begin
    edge_cfg_d  = edge_cfg_q;
    delay_cfg_d = delay_cfg_q;
    mask_d      = mask_q;
    if (access_wr && sel_edge) begin
      edge_cfg_d = edge_wr[15:0];
    end
    if (access_wr && sel_delay) begin
      delay_cfg_d = delay_wr[7:0];
    end
    if (access_wr && sel_mask) begin
      mask_d = mask_wr[STATUS_W-1:0];
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      edge_cfg_q  <= EDGE_CFG_RST;
      delay_cfg_q <= DELAY_CFG_RST;
      mask_q      <= MASK_RST;
    end else begin
      edge_cfg_q  <= edge_cfg_d;
      delay_cfg_q <= delay_cfg_d;
      mask_q      <= mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear; a new event in the clearing cycle wins

  always_comb begin
    // lost is judged on the status before any clear, so clearing a bit in
    // the very cycle a second edge arrives still reports the loss
    lost     = |(evt & status_q[NUM_CH-1:0]);
    set_bits = {lost, evt};
    clr_bits = (access_wr && sel_status) ? clr_wr[STATUS_W-1:0] : '0;
    status_d = (status_q & ~clr_bits) | set_bits;
    // diagnostics reach the pin only through mask bit 16
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      status_q <= STATUS_RST;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= irq_d;
    end
  end

  assign IRQ_OUT = irq_q;

endmodule // digital_input_edge_irq_filter

/* shared/di_pkg.sv */
package di_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int              NUM_CH       = 16;
  localparam int              EDGE_GROUP   = 2;
  localparam int              DELAY_GROUP  = 4;
  localparam int              NUM_EGRP     = NUM_CH / EDGE_GROUP;
  localparam int              NUM_DGRP     = NUM_CH / DELAY_GROUP;
  localparam int              CNT_W        = 19;
  localparam int              STATUS_W     = NUM_CH + 1;
  localparam int              LOST_BIT     = NUM_CH;
  localparam int              ADDR_W       = 12;

  typedef logic [CNT_W-1:0]    count_t;
  typedef logic [STATUS_W-1:0] status_t;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int              CLK_PERIOD_NS = 50;
  localparam int              DELAY_0P1_NS  = 100000;
  localparam int              DELAY_0P5_NS  = 500000;
  localparam int              DELAY_3_NS    = 3000000;
  localparam int              DELAY_15_NS   = 15000000;
  // least times, rounded up to whole cycles
  localparam count_t          DELAY_0P1_CYC     = count_t'((DELAY_0P1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam count_t          DELAY_0P5_CYC_DEF = count_t'((DELAY_0P5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam count_t          DELAY_3_CYC_DEF   = count_t'((DELAY_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam count_t          DELAY_15_CYC_DEF  = count_t'((DELAY_15_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0]      REG_IDX_IN_LOW    = 8'h88;
  localparam logic [7:0]      REG_IDX_IN_HIGH   = 8'h89;
  localparam logic [7:0]      REG_IDX_EDGE_CFG  = 8'h8A;
  localparam logic [7:0]      REG_IDX_DELAY_CFG = 8'h8B;
  localparam logic [7:0]      REG_IDX_STATUS    = 8'h8C;
  localparam logic [7:0]      REG_IDX_MASK      = 8'h8D;
  localparam logic [7:0]      REG_IDX_FILTERED  = 8'h8E;

  ////////////////////////////////////////////////////////////////////////////////
  // field encodings and reset values
  localparam logic [1:0]      EDGE_NONE    = 2'h0;
  localparam logic [1:0]      EDGE_RISE    = 2'h1;
  localparam logic [1:0]      EDGE_FALL    = 2'h2;
  localparam logic [1:0]      EDGE_BOTH    = 2'h3;
  localparam logic [1:0]      DLY_0P1      = 2'h0;
  localparam logic [1:0]      DLY_0P5      = 2'h1;
  localparam logic [1:0]      DLY_3        = 2'h2;
  localparam logic [1:0]      DLY_15       = 2'h3;
  localparam logic [15:0]     FAST_CHANNELS = 16'h000F;
  localparam logic [15:0]     EDGE_CFG_RST  = 16'h0000;
  localparam logic [7:0]      DELAY_CFG_RST = 8'hAA;
  localparam status_t         STATUS_RST    = 17'h00000;
  localparam status_t         MASK_RST      = 17'h00000;

endpackage

/* rtl/input_filter.sv */
`timescale 1ns/1ps
module input_filter
  import di_pkg::*;
(
  // clock and reset
  input  wire logic          CLOCK_IN,
  input  wire logic          RESET_IN,
  // channel
  input  wire logic          RAW_IN,
  input  wire di_pkg::count_t LIMIT_IN,
  output logic               LEVEL_OUT
);

  import di_pkg::*;

  count_t cnt_q, cnt_d;
  logic   level_q, level_d;

  ////////////////////////////////////////////////////////////////////////////////
  // the level follows the raw input only once it has held for LIMIT_IN cycles;
  // any bounce restarts the count
  always_comb begin
    cnt_d   = '0;
    level_d = level_q;
    if (RAW_IN != level_q) begin
      if (cnt_q >= LIMIT_IN - count_t'(1)) begin
        level_d = RAW_IN;
      end else begin
        cnt_d = cnt_q + count_t'(1);
      end
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  assign LEVEL_OUT = level_q;

endmodule // input_filter

/* test/field_sensors.sv */
`timescale 1ns/1ps
module field_sensors
  import di_pkg::*;
(
  // clock
  input  wire logic                      CLOCK_IN,
  // commanded contacts
  input  wire logic [di_pkg::NUM_CH-1:0] LEVEL_IN,
  // wires to the block
  output logic      [di_pkg::NUM_CH-1:0] FIELD_OUT
);
  import di_pkg::*;
  // contacts chatter back twice after a change, so the filter sees bounce
  logic [NUM_CH-1:0] prev_q  = '0;
  logic [NUM_CH-1:0] moved_q = '0;
  logic [2:0]        bnc_q   = 3'h0;
  always_ff @(posedge CLOCK_IN) begin
    prev_q <= LEVEL_IN;
    if (LEVEL_IN != prev_q) begin
      moved_q <= LEVEL_IN ^ prev_q;
      bnc_q   <= 3'h4;
    end else if (bnc_q != 3'h0) begin
      bnc_q <= bnc_q - 3'h1;
    end
  end
  assign FIELD_OUT = LEVEL_IN ^ (bnc_q[0] ? moved_q : '0);
endmodule // field_sensors

/* test/di_irq_assertions.sv */
`timescale 1ns/1ps
module di_irq_assertions
  import di_pkg::*;
(
  // clock and reset
  input wire logic                      CLOCK_IN,
  input wire logic                      RESET_IN,
  // apb
  input wire logic                      PSEL_IN,
  input wire logic                      PENABLE_IN,
  input wire logic                      PWRITE_IN,
  input wire logic [di_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0]               PWDATA_IN,
  input wire logic [3:0]                PSTRB_IN,
  input wire logic [31:0]               PRDATA_OUT,
  input wire logic                      PREADY_OUT,
  input wire logic                      PSLVERR_OUT,
  // field and interrupt
  input wire logic [di_pkg::NUM_CH-1:0] FIELD_IN,
  input wire logic                      IRQ_OUT
);
  import di_pkg::*;
  logic acc;
  logic hit;
  logic armed_q;
  logic armed_d;
  assign acc = PSEL_IN && PENABLE_IN;
  assign hit = PADDR_IN[1:0] == 2'h0 && PADDR_IN >= 12'h220 && PADDR_IN <= 12'h238;
  // no edge can be armed before software first writes the edge setting
  always_comb armed_d = armed_q | (acc && PWRITE_IN && PADDR_IN == 12'h228);
  always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
    if (RESET_IN) armed_q <= 1'b0;
    else armed_q <= armed_d;
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);
  ////////////////////////////////////////////////////////////////////////////////
  ready_always_a: assert property (PREADY_OUT) else $error("ready dropped");
  slverr_phase_a: assert property (PSLVERR_OUT |-> acc) else $error("error outside access");
  slverr_map_a: assert property (acc |-> PSLVERR_OUT == !hit) else $error("error flag wrong");
  unmapped_zero_a: assert property (acc && !PWRITE_IN && !hit |-> PRDATA_OUT == 32'h0) else $error("bad unmapped data");
  byte_width_a: assert property (acc && !PWRITE_IN && PADDR_IN inside {12'h220, 12'h224}
    |-> PRDATA_OUT[31:8] == 24'h0) else $error("input byte too wide");
  mask_off_a: assert property (acc && PWRITE_IN && PADDR_IN == 12'h234 && PSTRB_IN == 4'hF
    && PWDATA_IN[16:0] == 17'h0 |=> !IRQ_OUT) else $error("masked irq high");
  edge_none_a: assert property (!armed_q |-> !IRQ_OUT) else $error("irq with no edge set");
  no_status_a: assert property (!armed_q && acc && !PWRITE_IN && PADDR_IN == 12'h230
    |-> PRDATA_OUT == 32'h0) else $error("status with no edge set");
  irq_seen_c: cover property ($rose(IRQ_OUT));
  slverr_c: cover property (PSLVERR_OUT);
  mask_wr_c: cover property (acc && PWRITE_IN && PADDR_IN == 12'h234);
  lost_seen_c: cover property (acc && !PWRITE_IN && PADDR_IN == 12'h230 && PRDATA_OUT[16]);
endmodule // di_irq_assertions

bind digital_input_edge_irq_filter di_irq_assertions u_chk (.CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .FIELD_IN(FIELD_IN), .IRQ_OUT(IRQ_OUT));

/* test/digital_input_edge_irq_filter_tb.sv */
`timescale 1ns/1ps
module digital_input_edge_irq_filter_tb;
  import di_pkg::*;
  // short filter times keep the run brief; the fast delay stays real
  localparam int     D05 = 20;
  localparam int     D3  = 40;
  localparam int     D15 = 80;
  localparam int     D01 = int'(DELAY_0P1_CYC);
  logic              clk     = 1'b0;
  logic              rst     = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [NUM_CH-1:0] lvl     = '0;
  logic [NUM_CH-1:0] field;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              slv;
  int                err_total = 0;
  int                checked   = 0;
  int                cyc       = 0;
  int                tnum      = 0;
  logic [31:0]       rvals [7] = '{32'h0, 32'h0, 32'h0, 32'hAA, 32'h0, 32'h0, 32'h0};
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  field_sensors u_sensors (.CLOCK_IN(clk), .LEVEL_IN(lvl), .FIELD_OUT(field));
  digital_input_edge_irq_filter #(.DELAY_0P5_CYC(count_t'(D05)), .DELAY_3_CYC(count_t'(D3)),
    .DELAY_15_CYC(count_t'(D15))) dut (.CLOCK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FIELD_IN(field), .IRQ_OUT(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  // irq settles after the access edge, so look half a cycle later
  task automatic irq_is(input logic [31:0] e);
    @(negedge clk);
    chk(32'(irq), e);
  endtask
  task automatic ended;
    $display("test %0d done", tnum);
    tnum++;
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(12'h220 + 12'(4 * i), rvals[i]);
    ended();
    rd(12'h240, 32'h0);
    chk(32'(slv), 32'h1);
    rd(12'h221, 32'h0);
    chk(32'(slv), 32'h1);
    wr(12'h220, 32'hFF);
    chk(32'(slv), 32'h0);
    rd(12'h220, 32'h0);
    ended();
    lvl <= 16'h8001;
    repeat (20) @(posedge clk);
    rd(12'h238, 32'h0);
    repeat (D3 + 20) @(posedge clk);
    rd(12'h220, 32'h01);
    rd(12'h224, 32'h80);
    rd(12'h230, 32'h0);
    ended();
    wr(12'h228, 32'h8001);
    wr(12'h234, 32'h1FFFF);
    lvl <= 16'h0003;
    repeat (D3 + 20) @(posedge clk);
    rd(12'h230, 32'h8002);
    irq_is(32'h1);
    wr(12'h234, 32'h0);
    irq_is(32'h0);
    wr(12'h234, 32'h1FFFF);
    ended();
    lvl <= 16'h0001;
    repeat (D3 + 20) @(posedge clk);
    lvl <= 16'h0003;
    repeat (D3 + 20) @(posedge clk);
    rd(12'h230, 32'h18002);
    wr(12'h230, 32'h8002);
    rd(12'h230, 32'h10000);
    irq_is(32'h1);
    wr(12'h234, 32'hFFFF);
    irq_is(32'h0);
    wr(12'h230, 32'h1FFFF);
    rd(12'h230, 32'h0);
    ended();
    wr(12'h22C, 32'hD0);
    rd(12'h22C, 32'hD0);
    lvl <= 16'h1117;
    repeat (8) @(posedge clk);
    rd(12'h238, 32'h0003);
    repeat (D05) @(posedge clk);
    rd(12'h238, 32'h0113);
    repeat (D15) @(posedge clk);
    rd(12'h238, 32'h1113);
    repeat (D01) @(posedge clk);
    rd(12'h238, 32'h1117);
    ended();
    // both edges on the last pair: each channel of the pair follows the one setting
    wr(12'h228, 32'hC001);
    lvl <= 16'hD117;
    repeat (D15 + 20) @(posedge clk);
    rd(12'h230, 32'hC000);
    irq_is(32'h1);
    wr(12'h230, 32'hC000);
    lvl <= 16'h1117;
    repeat (D15 + 20) @(posedge clk);
    rd(12'h230, 32'hC000);
    wr(12'h230, 32'hC000);
    rd(12'h230, 32'h0);
    irq_is(32'h0);
    ended();
    // reset in mid-run: registers and filters start over, inputs held high return later
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(12'h220 + 12'(4 * i), rvals[i]);
    irq_is(32'h0);
    repeat (D3 + 20) @(posedge clk);
    rd(12'h238, 32'h1117);
    rd(12'h230, 32'h0);
    ended();
    conclude();
  end
endmodule // digital_input_edge_irq_filter_tb
